/* cis_consts.vh */
// offsets, field positions, reset values and limits of the interrupt and status unit
`ifndef CIS_CONSTS_VH
`define CIS_CONSTS_VH
// register byte offsets
`define CIS_OFS_MODE 12'h000
`define CIS_OFS_EN_SET 12'h004
`define CIS_OFS_EN_CLR 12'h008
`define CIS_OFS_MASK 12'h00C
`define CIS_OFS_STATUS 12'h010
// mailbox event field
`define CIS_MB_LSB 0
`define CIS_MB_MSB 7
// fault confinement, power and timer fields
`define CIS_BIT_ERROR_ACTIVE_FLAG 16
`define CIS_BIT_WARN 17
`define CIS_BIT_ERROR_PASSIVE_FLAG 18
`define CIS_BIT_BUS_OFF_FLAG 19
`define CIS_BIT_SLEEP 20
`define CIS_BIT_WAKE 21
`define CIS_BIT_TIMER_OVERFLOW_FLAG 22
`define CIS_BIT_TIMESTAMP_FLAG 23
// protocol error field: crc, stuffing, ack, form, bit
`define CIS_ERR_LSB 24
`define CIS_ERR_MSB 28
// busy bits, status word only
`define CIS_BIT_RECEIVER_BUSY 29
`define CIS_BIT_TRANSMITTER_BUSY 30
`define CIS_BIT_OVLB 31
// top source bit that can be masked
`define CIS_SRC_MSB 28
// mode register fields
`define CIS_MODE_LPM 1
`define CIS_MODE_TSEL 4
// writable bits
`define CIS_MASK_VALID 32'h1FFF_00FF
`define CIS_MODE_VALID 32'h0000_0012
// reset values
`define CIS_MODE_RST 32'h0000_0000
`define CIS_MASK_RST 32'h0000_0000
`define CIS_FLAG_RST 5'h00
// error counter limits
`define CIS_WARN_LIMIT 9'h060
`define CIS_PASSIVE_LIMIT 9'h080
`define CIS_BUSOFF_LIMIT 9'h100
// timer wrap points
`define CIS_TIMER_MAX 16'hFFFF
`define CIS_TIMER_MIN 16'h0000
// bus responses
`define CIS_RESP_OKAY 2'h0
`define CIS_RESP_SLVERR 2'h2
`endif

/* cis_axil_slave.v */
// axi4-lite slave front end that turns bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none
`include "cis_consts.vh"
module cis_axil_slave #(
	parameter ADDR_W = 12
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_W-1:0] awaddr,
	input wire awvalid,
	output wire awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output wire wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [ADDR_W-1:0] araddr,
	input wire arvalid,
	output wire arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	output wire reg_wr_en,
	output reg [ADDR_W-1:0] reg_wr_addr,
	output reg [31:0] reg_wr_data,
	output reg [3:0] reg_wr_strb,
	input wire reg_wr_hit,
	output wire reg_rd_en,
	output wire [ADDR_W-1:0] reg_rd_addr,
	input wire [31:0] reg_rd_data,
	input wire reg_rd_hit
);
	reg aw_held; // write address captured
	reg w_held; // write data captured
	// each channel is taken once, in either order, while no response waits
	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	// the register write fires once both halves are in
	assign reg_wr_en = aw_held && w_held && !bvalid;
	// a read is taken whenever no read data waits
	assign arready = !rvalid;
	assign reg_rd_en = arvalid && !rvalid;
	assign reg_rd_addr = araddr;
	// write channel capture and response
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `CIS_RESP_OKAY;
			reg_wr_addr <= {ADDR_W{1'b0}};
			reg_wr_data <= 32'h0000_0000;
			reg_wr_strb <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held <= 1'b1;
				reg_wr_addr <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_held <= 1'b1;
				reg_wr_data <= wdata;
				reg_wr_strb <= wstrb;
			end
			if (reg_wr_en)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= reg_wr_hit ? `CIS_RESP_OKAY : `CIS_RESP_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end
	// read channel: data sampled at the edge that takes the address
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `CIS_RESP_OKAY;
		end
		else if (reg_rd_en)
		begin
			rvalid <= 1'b1;
			rdata <= reg_rd_hit ? reg_rd_data : 32'h0000_0000;
			rresp <= reg_rd_hit ? `CIS_RESP_OKAY : `CIS_RESP_SLVERR;
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
	end
endmodule
`default_nettype wire

/* cis_fault_confine.v */
// fault confinement decode of the transmit and receive error counters
`timescale 1ns/1ps
`default_nettype none
`include "cis_consts.vh"
module cis_fault_confine #(
	parameter CNT_W = 9
) (
	input wire aclk,
	input wire aresetn,
	input wire [CNT_W-1:0] tx_count,
	input wire [CNT_W-1:0] rx_count,
	output reg error_active,
	output reg warning,
	output reg error_passive,
	output reg bus_off
);
	wire next_passive; // passive condition this cycle
	wire next_bus_off; // bus-off condition this cycle
	assign next_passive = (tx_count >= `CIS_PASSIVE_LIMIT) ||
		((rx_count >= `CIS_PASSIVE_LIMIT) && (rx_count < `CIS_BUSOFF_LIMIT));
	assign next_bus_off = tx_count >= `CIS_BUSOFF_LIMIT;
	// flags follow the counters, one cycle behind, and clear on their own
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			error_active <= 1'b1;
			warning <= 1'b0;
			error_passive <= 1'b0;
			bus_off <= 1'b0;
		end
		else
		begin
			error_active <= !next_passive && !next_bus_off;
			warning <= (tx_count > `CIS_WARN_LIMIT) || (rx_count > `CIS_WARN_LIMIT);
			error_passive <= next_passive;
			bus_off <= next_bus_off;
		end
	end
endmodule
`default_nettype wire

/* cis_status_unit.v */
// interrupt mask and status word of the bus-network controller
//
// Function
// - enable port write one sets mask bit
// - disable port write one clears mask bit
// - mask view reads currently enabled sources
// - bits 0-7 mailboxes, bits 8-15 unused
// - fault, power, timer and error field order
// - busy bits 29-31 live in status only
// - mailbox bit set on ready or abort
// - error active when neither passive nor off
// - warning when either counter above 96
// - passive at tx>=128 or rx 128..255
// - bus off while tx counter at least 256
// - sleep bit high while in low power
// - wakeup bit is inverse of low power
// - wakeup event resyncs, then traffic resumes
// - timer overflow set on FFFF to 0000
// - status read clears overflow, returns old value
// - timestamp flag on selected frame point, read-clear
// - status read clears protocol error flags
// - overflow with mask enabled raises interrupt
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cis_consts.vh"
module cis_status_unit #(
	parameter ADDR_W = 12,
	parameter MB_N = 8,
	parameter CNT_W = 9,
	parameter TIMER_W = 16
) (
	input wire aclk,
	input wire aresetn,
	// register bus, write side
	input wire [ADDR_W-1:0] awaddr,
	input wire awvalid,
	output wire awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output wire wready,
	output wire [1:0] bresp,
	output wire bvalid,
	input wire bready,
	// register bus, read side
	input wire [ADDR_W-1:0] araddr,
	input wire arvalid,
	output wire arready,
	output wire [31:0] rdata,
	output wire [1:0] rresp,
	output wire rvalid,
	input wire rready,
	// mailbox flags
	input wire [MB_N-1:0] mailbox_ready,
	input wire [MB_N-1:0] mailbox_aborted,
	// error counters
	input wire [CNT_W-1:0] tx_error_count,
	input wire [CNT_W-1:0] rx_error_count,
	// internal timer value
	input wire [TIMER_W-1:0] timer_value,
	// frame point pulses
	input wire frame_start,
	input wire frame_end,
	// protocol error pulses: crc, stuffing, ack, form, bit
	input wire [4:0] protocol_error,
	// engine busy levels
	input wire receiver_busy,
	input wire transmitter_busy,
	input wire overload_busy,
	// bus activity seen while asleep
	input wire wakeup_event,
	// interrupt request, level
	output wire irq,
	// one-cycle pulse: resynchronise to the bus
	output reg resync_request,
	// high while frames may be sent and received
	output wire traffic_enable
);
	// power states
	localparam ST_ACTIVE = 2'd0;
	localparam ST_SLEEP = 2'd1;
	localparam ST_RESYNC = 2'd2;

	wire wr_en; // register write strobe
	wire [ADDR_W-1:0] wr_addr; // register write address
	wire [31:0] wr_data; // register write data
	wire [3:0] wr_strb; // register write byte lanes
	wire rd_en; // register read strobe
	wire [ADDR_W-1:0] rd_addr; // register read address
	reg [31:0] rd_data; // read mux output
	wire wr_hit; // write address is mapped
	wire rd_hit; // read address is mapped

	wire flag_active; // fault confinement flags
	wire flag_warn;
	wire flag_passive;
	wire flag_off;

	reg [31:0] mode; // mode register
	reg [31:0] mask; // interrupt mask
	reg [1:0] power_state; // low power state machine
	reg [1:0] next_power_state;
	reg [MB_N-1:0] mailbox_event; // mailbox event bits
	reg timer_overflow_flag; // sticky, read-clear
	reg timestamp_flag; // sticky, read-clear
	reg [4:0] protocol_flags; // sticky, read-clear
	reg [TIMER_W-1:0] timer_prev; // timer value one cycle back
	reg [31:0] next_mask;
	reg [31:0] next_mode;

	wire [31:0] status_word; // assembled status
	wire [31:0] wr_bits; // write data limited to its byte lanes
	wire status_read; // status word is being read
	wire timer_wrap; // timer rolled over this cycle
	wire stamp_point; // selected frame point seen
	wire sleeping; // in low power mode
	wire wake; // wakeup accepted this cycle

	// true when an address selects the word at a given offset
	function is_reg;
		input [ADDR_W-1:0] addr;
		input [ADDR_W-1:0] ofs;
		begin
			is_reg = addr[ADDR_W-1:2] == ofs[ADDR_W-1:2];
		end
	endfunction

	// true for any of the five mapped words
	function is_mapped;
		input [ADDR_W-1:0] addr;
		begin
			is_mapped = is_reg(addr, `CIS_OFS_MODE) || is_reg(addr, `CIS_OFS_EN_SET) ||
				is_reg(addr, `CIS_OFS_EN_CLR) || is_reg(addr, `CIS_OFS_MASK) ||
				is_reg(addr, `CIS_OFS_STATUS);
		end
	endfunction

	// bus slave front end
	cis_axil_slave #(
		.ADDR_W(ADDR_W)
	) u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.reg_wr_en(wr_en),
		.reg_wr_addr(wr_addr),
		.reg_wr_data(wr_data),
		.reg_wr_strb(wr_strb),
		.reg_wr_hit(wr_hit),
		.reg_rd_en(rd_en),
		.reg_rd_addr(rd_addr),
		.reg_rd_data(rd_data),
		.reg_rd_hit(rd_hit)
	);

	// error counter decode
	cis_fault_confine #(
		.CNT_W(CNT_W)
	) u_fault (
		.aclk(aclk),
		.aresetn(aresetn),
		.tx_count(tx_error_count),
		.rx_count(rx_error_count),
		.error_active(flag_active),
		.warning(flag_warn),
		.error_passive(flag_passive),
		.bus_off(flag_off)
	);

	// address decode
	assign wr_hit = is_mapped(wr_addr);
	assign rd_hit = is_mapped(rd_addr);

	// byte lanes that are not strobed carry no ones
	assign wr_bits = wr_data & {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

	// a status read takes effect at the edge the address is taken
	assign status_read = rd_en && is_reg(rd_addr, `CIS_OFS_STATUS);

	// roll-over from the top count to zero
	assign timer_wrap = (timer_prev == `CIS_TIMER_MAX) && (timer_value == `CIS_TIMER_MIN);

	// frame point chosen by the mode register
	assign stamp_point = mode[`CIS_MODE_TSEL] ? frame_end : frame_start;

	// low power and wakeup
	assign sleeping = power_state == ST_SLEEP;
	assign wake = sleeping && wakeup_event;
	assign traffic_enable = power_state == ST_ACTIVE;

	// status word, unused bits 8 to 15 read zero
	assign status_word = {
		overload_busy,
		transmitter_busy,
		receiver_busy,
		protocol_flags,
		timestamp_flag,
		timer_overflow_flag,
		!sleeping,
		sleeping,
		flag_off,
		flag_passive,
		flag_warn,
		flag_active,
		8'h00,
		mailbox_event
	};

	// interrupt: any enabled source that is high, busy bits excluded
	assign irq = |(status_word[`CIS_SRC_MSB:0] & mask[`CIS_SRC_MSB:0]);

	// read mux; write-only ports read as zero
	always @*
	begin
		rd_data = 32'h0000_0000;
		if (is_reg(rd_addr, `CIS_OFS_MODE))
			rd_data = mode;
		else if (is_reg(rd_addr, `CIS_OFS_MASK))
			rd_data = mask;
		else if (is_reg(rd_addr, `CIS_OFS_STATUS))
			rd_data = status_word;
	end

	// mask update from the enable and disable ports
	always @*
	begin
		next_mask = mask;
		if (wr_en && is_reg(wr_addr, `CIS_OFS_EN_SET))
			next_mask = mask | (wr_bits & `CIS_MASK_VALID);
		else if (wr_en && is_reg(wr_addr, `CIS_OFS_EN_CLR))
			next_mask = mask & ~(wr_bits & `CIS_MASK_VALID);
	end

	// mode update; a wakeup drops the low power request
	always @*
	begin
		next_mode = mode;
		if (wr_en && is_reg(wr_addr, `CIS_OFS_MODE))
			next_mode = (mode & ~({{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}}
				& `CIS_MODE_VALID)) | (wr_bits & `CIS_MODE_VALID);
		if (wake)
			next_mode[`CIS_MODE_LPM] = 1'b0;
	end

	// low power state machine
	always @*
	begin
		next_power_state = power_state;
		case (power_state)
			ST_ACTIVE:
			begin
				// enter only once neither transmitter nor receiver is busy; overload busy is not checked
				if (mode[`CIS_MODE_LPM] && !transmitter_busy && !receiver_busy)
					next_power_state = ST_SLEEP;
			end
			ST_SLEEP:
			begin
				// bus activity wakes; software may also leave
				if (wake)
					next_power_state = ST_RESYNC;
				else if (!mode[`CIS_MODE_LPM])
					next_power_state = ST_ACTIVE;
			end
			ST_RESYNC:
			begin
				// wait for the frame in flight to end
				if (!receiver_busy)
					next_power_state = ST_ACTIVE;
			end
			default:
			begin
				next_power_state = ST_ACTIVE;
			end
		endcase
	end

	// registers: mode, mask, power state, timer history
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode <= `CIS_MODE_RST;
			mask <= `CIS_MASK_RST;
			power_state <= ST_ACTIVE;
			timer_prev <= `CIS_TIMER_MIN;
			resync_request <= 1'b0;
		end
		else
		begin
			mode <= next_mode;
			mask <= next_mask;
			power_state <= next_power_state;
			timer_prev <= timer_value;
			resync_request <= wake;
		end
	end

	// mailbox event bits follow each mailbox's ready or abort flag
	genvar i;
	generate
		for (i = 0; i < MB_N; i = i + 1)
		begin : g_mb
			always @(posedge aclk)
			begin
				if (!aresetn)
					mailbox_event[i] <= 1'b0;
				else
					mailbox_event[i] <= mailbox_ready[i] | mailbox_aborted[i];
			end
		end
	endgenerate

	// read-clear flags; a new event in the read cycle survives
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_overflow_flag <= 1'b0;
			timestamp_flag <= 1'b0;
			protocol_flags <= `CIS_FLAG_RST;
		end
		else
		begin
			timer_overflow_flag <= (timer_overflow_flag && !status_read) || timer_wrap;
			timestamp_flag <= (timestamp_flag && !status_read) || stamp_point;
			protocol_flags <= (protocol_flags & {5{!status_read}}) | protocol_error;
		end
	end
endmodule
`default_nettype wire

/* cis_bus_node.sv */
// behavioural model of the other bus nodes and of the controller timer feeding the unit
`timescale 1ns/1ps
`default_nettype none
module cis_bus_node (
	input wire logic aclk,
	output logic [8:0] tx_error_count,
	output logic [8:0] rx_error_count,
	output logic [15:0] timer_value,
	output logic frame_start,
	output logic frame_end,
	output logic [4:0] protocol_error,
	output logic receiver_busy,
	output logic transmitter_busy,
	output logic overload_busy,
	output logic wakeup_event
);
	logic load_req = 1'b0; // one-cycle request to reload the timer
	logic [15:0] load_val = 16'h0000; // value loaded on request
	// quiet bus, empty counters
	initial
	begin
		{tx_error_count, rx_error_count, timer_value} = 34'h0;
		{frame_start, frame_end, protocol_error, receiver_busy, transmitter_busy, overload_busy} = 10'h0;
		wakeup_event = 1'b0;
	end
	// free running timer; a reload lets a wrap come soon
	always @(posedge aclk)
		timer_value <= load_req ? load_val : timer_value + 16'h0001;
	task set_counts(input logic [8:0] t, input logic [8:0] r);
		@(posedge aclk);
		tx_error_count <= t;
		rx_error_count <= r;
	endtask
	task set_busy(input logic [2:0] b);
		@(posedge aclk);
		{overload_busy, transmitter_busy, receiver_busy} <= b;
	endtask
	task pulse_err(input logic [4:0] e);
		@(posedge aclk);
		protocol_error <= e;
		@(posedge aclk);
		protocol_error <= 5'h00;
	endtask
	task pulse_frame(input logic s, input logic e);
		@(posedge aclk);
		frame_start <= s;
		frame_end <= e;
		@(posedge aclk);
		{frame_start, frame_end} <= 2'b00;
	endtask
	// bus activity while asleep; the clock is never stopped here
	task wake();
		@(posedge aclk);
		wakeup_event <= 1'b1;
		@(posedge aclk);
		wakeup_event <= 1'b0;
	endtask
	task load_timer(input logic [15:0] v);
		@(posedge aclk);
		load_val <= v;
		load_req <= 1'b1;
		@(posedge aclk);
		load_req <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* cis_status_unit_chk.sv */
// assertion checker for the interrupt and status unit
`timescale 1ns/1ps
`default_nettype none
`include "cis_consts.vh"
module cis_status_unit_chk #(
	parameter ADDR_W = 12,
	parameter CNT_W = 9
) (
	input wire aclk,
	input wire aresetn,
	input wire [ADDR_W-1:0] araddr,
	input wire arvalid,
	input wire arready,
	input wire [31:0] rdata,
	input wire rvalid,
	input wire rready,
	input wire [CNT_W-1:0] tx_error_count,
	input wire [CNT_W-1:0] rx_error_count,
	input wire receiver_busy,
	input wire transmitter_busy,
	input wire overload_busy,
	input wire resync_request,
	input wire traffic_enable
);
	logic srd = 1'b0; // high while a status read answer first shows
	wire [2:0] busy = {overload_busy, transmitter_busy, receiver_busy};
	wire [CNT_W-1:0] tx = tx_error_count;
	wire [CNT_W-1:0] rx = rx_error_count;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// remember that the taken read went to the status word
	always @(posedge aclk)
		srd <= aresetn && arvalid && arready && araddr == `CIS_OFS_STATUS;
	// status read with counters and busy levels held around it
	sequence s_rd;
		srd && $past(tx, 1) == $past(tx, 3) && $past(rx, 1) == $past(rx, 3) && $past(busy, 1) == $past(busy, 3);
	endsequence
	property p_bus_off_flag;
		s_rd |-> rdata[19] == ($past(tx, 2) >= `CIS_BUSOFF_LIMIT);
	endproperty
	a_bus_off_flag: assert property (p_bus_off_flag) else $error("bus off bit wrong");
	property p_error_passive_flag;
		s_rd |-> rdata[18] == ($past(tx, 2) >= `CIS_PASSIVE_LIMIT
			|| ($past(rx, 2) >= `CIS_PASSIVE_LIMIT && $past(rx, 2) < `CIS_BUSOFF_LIMIT));
	endproperty
	a_error_passive_flag: assert property (p_error_passive_flag) else $error("passive bit wrong");
	property p_warn;
		s_rd |-> rdata[17] == ($past(tx, 2) > `CIS_WARN_LIMIT || $past(rx, 2) > `CIS_WARN_LIMIT);
	endproperty
	a_warn: assert property (p_warn) else $error("warning bit wrong");
	property p_error_active_flag;
		srd |-> rdata[16] == !(rdata[18] || rdata[19]);
	endproperty
	a_error_active_flag: assert property (p_error_active_flag) else $error("active bit wrong");
	property p_wake;
		srd |-> rdata[21] == !rdata[20];
	endproperty
	a_wake: assert property (p_wake) else $error("wakeup bit not inverse of sleep");
	property p_unused;
		srd |-> rdata[15:8] == 8'h00;
	endproperty
	a_unused: assert property (p_unused) else $error("unused status bits set");
	property p_busy;
		s_rd |-> rdata[31:29] == $past(busy, 1);
	endproperty
	a_busy: assert property (p_busy) else $error("busy bits wrong");
	property p_resync;
		resync_request |-> !traffic_enable ##1 !resync_request;
	endproperty
	a_resync: assert property (p_resync) else $error("resync pulse wrong");
	c_srd: cover property (srd);
	c_resync: cover property (resync_request);
	c_sleep: cover property (srd && rdata[20]);
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench for the interrupt and status unit
`timescale 1ns/1ps
`default_nettype none
`include "cis_consts.vh"
module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hF;
	logic [7:0] mailbox_ready = 8'h00, mailbox_aborted = 8'h00;
	wire awready, wready, bvalid, arready, rvalid, irq, resync_request, traffic_enable;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [8:0] tx_error_count, rx_error_count;
	wire [15:0] timer_value;
	wire [4:0] protocol_error;
	wire frame_start, frame_end, receiver_busy, transmitter_busy, overload_busy, wakeup_event;
	int error_cnt = 0, n_compared = 0, i, k;
	logic [31:0] m, s, r; // mask model, stimulus word, last read data
	logic [1:0] rsp; // last response code
	logic [8:0] a, b; // transmit and receive counts
	logic [2:0] bz; // busy levels
	logic [8:0] tt [10] = '{9'h060, 9'h061, 9'h000, 9'h080, 9'h07F, 9'h000, 9'h000, 9'h0FF, 9'h100, 9'h1FF};
	logic [8:0] rt [10] = '{9'h060, 9'h000, 9'h061, 9'h000, 9'h0FF, 9'h080, 9'h100, 9'h000, 9'h000, 9'h1FF};
	// the clock keeps running through sleep so a wakeup is always seen
	always #20 aclk = ~aclk;
	cis_status_unit u_cis_status_unit (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.mailbox_ready, .mailbox_aborted, .tx_error_count, .rx_error_count, .timer_value, .frame_start,
		.frame_end, .protocol_error, .receiver_busy, .transmitter_busy, .overload_busy, .wakeup_event, .irq,
		.resync_request, .traffic_enable);
	cis_bus_node u_cis_bus_node (.aclk, .tx_error_count, .rx_error_count, .timer_value, .frame_start,
		.frame_end, .protocol_error, .receiver_busy, .transmitter_busy, .overload_busy, .wakeup_event);
	task automatic summarize();
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		n_compared++;
		if (got !== e)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask
	// a handshake that never finishes ends the run
	task automatic hung();
		error_cnt++;
		summarize();
	endtask
	// one write: address and data offered together, each released when taken
	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		int t;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'b111;
		for (t = 0; t < 50; t++)
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid)
			begin
				bready <= 1'b0;
				rsp = bresp;
				break;
			end
		end
		if (t == 50) hung();
	endtask
	// one read; data and response land in r and rsp
	task automatic rd(input logic [11:0] ad);
		int t;
		@(posedge aclk);
		araddr <= ad;
		{arvalid, rready} <= 2'b11;
		for (t = 0; t < 50; t++)
		begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid)
			begin
				rready <= 1'b0;
				r = rdata;
				rsp = rresp;
				break;
			end
		end
		if (t == 50) hung();
	endtask
	// expected bus_off_flag, passive, warning and active bits
	function automatic logic [3:0] fc(input logic [8:0] t, input logic [8:0] q);
		logic bo, p;
		bo = t >= 9'h100;
		p = t >= 9'h080 || (q >= 9'h080 && q < 9'h100);
		fc = {bo, p, t > 9'h060 || q > 9'h060, !(bo || p)};
	endfunction
	initial
	begin
		i = $urandom(32'hc5f55269);
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		// mask built through the set and clear ports
		m = 32'h0000_0000;
		for (i = 0; i < 24; i++)
		begin
			s = (i % 6 == 5) ? 32'hFFFF_FFFF : $urandom();
			wr(i[0] ? `CIS_OFS_EN_CLR : `CIS_OFS_EN_SET, s);
			m = i[0] ? m & ~s : m | (s & `CIS_MASK_VALID);
			rd(`CIS_OFS_MASK);
			chk(r, m);
		end
		// byte lanes 0 and 2 only: the other lanes of the clear word are ignored
		wstrb <= 4'h5;
		wr(`CIS_OFS_EN_CLR, 32'hFFFF_FFFF);
		chk(rsp, `CIS_RESP_OKAY);
		m = m & 32'hFF00_FF00;
		rd(`CIS_OFS_MASK);
		chk(r, m);
		wstrb <= 4'hF;
		// unmapped and read-only words take no write
		wr(12'h014, 32'hFFFF_FFFF);
		chk(rsp, `CIS_RESP_SLVERR);
		wr(`CIS_OFS_MASK, 32'hFFFF_FFFF);
		chk(rsp, `CIS_RESP_OKAY);
		rd(`CIS_OFS_MASK);
		chk(r, m);
		rd(`CIS_OFS_EN_SET);
		chk(r, 32'h0000_0000);
		rd(`CIS_OFS_EN_CLR);
		chk(r, 32'h0000_0000);
		rd(12'h014);
		chk({r[29:0], rsp}, {30'h0, `CIS_RESP_SLVERR});
		// counter boundaries first, then random counts, busy levels and mailbox events
		for (i = 0; i < 20; i++)
		begin
			a = i < 10 ? tt[i] : $urandom();
			b = i < 10 ? rt[i] : $urandom();
			bz = $urandom();
			u_cis_bus_node.set_counts(a, b);
			u_cis_bus_node.set_busy(bz);
			mailbox_ready <= $urandom();
			mailbox_aborted <= $urandom();
			repeat (3) @(posedge aclk);
			rd(`CIS_OFS_STATUS);
			chk(r[19:16], fc(a, b));
			chk(r[31:29], bz);
			chk(r[15:0], {8'h00, mailbox_ready | mailbox_aborted});
			chk(r[21:20], 2'b10);
		end
		// timer wrap raises the interrupt through its mask bit only
		wr(`CIS_OFS_EN_CLR, 32'hFFFF_FFFF);
		wr(`CIS_OFS_EN_SET, 32'h0040_0000);
		rd(`CIS_OFS_STATUS);
		u_cis_bus_node.load_timer(16'hFFFE);
		repeat (4) @(posedge aclk);
		chk(irq, 1'b1);
		rd(`CIS_OFS_STATUS);
		chk(r[22], 1'b1);
		chk(irq, 1'b0);
		rd(`CIS_OFS_STATUS);
		chk(r[22], 1'b0);
		// each protocol error alone, cleared by the read that reports it
		for (i = 0; i < 5; i++)
		begin
			u_cis_bus_node.pulse_err(5'h01 << i);
			rd(`CIS_OFS_STATUS);
			chk(r[28:24], 32'h1 << i);
			rd(`CIS_OFS_STATUS);
			chk(r[28:24], 32'h0);
		end
		// timestamp point select: the other frame point is ignored
		for (k = 0; k < 2; k++)
		begin
			wr(`CIS_OFS_MODE, k << 4);
			u_cis_bus_node.pulse_frame(k == 1, k == 0);
			rd(`CIS_OFS_STATUS);
			chk(r[23], 1'b0);
			u_cis_bus_node.pulse_frame(k == 0, k == 1);
			rd(`CIS_OFS_STATUS);
			chk(r[23], 1'b1);
			rd(`CIS_OFS_STATUS);
			chk(r[23], 1'b0);
		end
		// sleep, then a wakeup while the receiver is still busy
		u_cis_bus_node.set_busy(3'b000);
		wr(`CIS_OFS_MODE, 32'h0000_0002);
		repeat (3) @(posedge aclk);
		chk(traffic_enable, 1'b0);
		rd(`CIS_OFS_STATUS);
		chk(r[21:20], 2'b01);
		u_cis_bus_node.set_busy(3'b001);
		u_cis_bus_node.wake();
		for (i = 0; i < 20 && resync_request !== 1'b1; i++)
			@(posedge aclk);
		chk(i < 20, 1'b1);
		chk(traffic_enable, 1'b0);
		u_cis_bus_node.set_busy(3'b000);
		repeat (3) @(posedge aclk);
		chk(traffic_enable, 1'b1);
		rd(`CIS_OFS_STATUS);
		chk(r[21:20], 2'b10);
		rd(`CIS_OFS_MODE);
		chk(r, 32'h0000_0000);
		summarize();
	end
	// limit on the whole run
	initial
	begin
		#2000000;
		hung();
	end
endmodule
bind cis_status_unit cis_status_unit_chk #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_cis_status_unit_chk (.aclk, .aresetn,
	.araddr, .arvalid, .arready, .rdata, .rvalid, .rready, .tx_error_count, .rx_error_count, .receiver_busy,
	.transmitter_busy, .overload_busy, .resync_request, .traffic_enable);
`default_nettype wire
